// ---- alsm_defines.vh ----
// Constants for the slave application-layer state machine
`ifndef ALSM_DEFINES_VH
`define ALSM_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define ALSM_OFS_STATE_REQUEST 16'h0120
`define ALSM_OFS_STATE_REPORT 16'h0130
`define ALSM_OFS_ERROR_CODE 16'h0134

// ****************************************
// Field positions
// ****************************************
`define ALSM_STATE_MSB 3
`define ALSM_ACK_BIT 4
`define ALSM_CHANGE_BIT 4

// ****************************************
// State codes, shared by request and report
// ****************************************
`define ALSM_ST_INIT 4'h1
`define ALSM_ST_PREOP 4'h2
`define ALSM_ST_BOOT 4'h3
`define ALSM_ST_SAFEOP 4'h4
`define ALSM_ST_OP 4'h8

// ****************************************
// Transition error codes
// ****************************************
`define ALSM_ERR_NONE 16'h0000
`define ALSM_ERR_UNSPEC 16'h0001
`define ALSM_ERR_BAD_CHANGE 16'h0011
`define ALSM_ERR_UNKNOWN 16'h0012
`define ALSM_ERR_MBX_BOOT 16'h0015
`define ALSM_ERR_MBX_PREOP 16'h0016
`define ALSM_ERR_SM_CFG 16'h0017
`define ALSM_ERR_SM_WDOG 16'h001B
`define ALSM_ERR_OUT_CFG 16'h001D
`define ALSM_ERR_IN_CFG 16'h001E

// ****************************************
// Reset values
// ****************************************
`define ALSM_RST_REQUEST 16'h0001
`define ALSM_RST_STATE 4'h1
`define ALSM_RST_CODE 16'h0000

`endif

// ---- alsm_master.sv ----
// Fieldbus master model issuing register cycles
`timescale 1ns/1ps
module alsm_master (
  input wire clk,
  input wire reg_rvalid,
  input wire [15:0] reg_rdata,
  output reg [15:0] reg_addr = 16'h0000,
  output reg reg_wr = 1'b0,
  output reg [15:0] reg_wdata = 16'h0000,
  output reg reg_rd = 1'b0
);
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= {d[15:8], 3'h0, d[4:0]};
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
    end
  endtask
  // Answer is fixed one cycle after the read strobe
  task rd(input [15:0] a, output [15:0] q);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      q = (reg_rvalid === 1'b1) ? reg_rdata : 16'hDEAD;
    end
  endtask
endmodule // alsm_master

// ---- alsm_monitor.sv ----
// Port checks for the slave state machine
`timescale 1ns/1ps
module alsm_monitor (
  input wire clk,
  input wire rstn,
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire reg_rvalid,
  input wire mbx_cfg_ok,
  input wire sm_watchdog_expired,
  input wire out_cfg_fault,
  input wire in_cfg_fault,
  input wire unspecified_fault,
  input wire [3:0] current_state,
  input wire change_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Faults override requests, so request checks need a quiet cycle
  wire quiet = !(sm_watchdog_expired | out_cfg_fault | in_cfg_fault | unspecified_fault);
  wire req_wr = reg_wr && reg_addr == 16'h0120 && quiet;
  sequence s_req(r);
    req_wr && reg_wdata[3:0] == r;
  endsequence
  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_report;
    reg_rd && reg_addr == 16'h0130 |=> reg_rdata[4:0] == {$past(change_flag), $past(current_state)};
  endproperty
  a_report: assert property (p_report) else $error("bad status read");
  property p_ack1; s_req(current_state) ##0 reg_wdata[4] |=> !change_flag; endproperty
  a_ack1: assert property (p_ack1) else $error("ack kept flag");
  property p_ack0; s_req(current_state) ##0 !reg_wdata[4] |=> $stable(change_flag); endproperty
  a_ack0: assert property (p_ack0) else $error("flag moved");
  property p_refuse;
    s_req(4'h8) ##0 current_state == 4'h1 |=> current_state == 4'h1 && change_flag;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad change taken");
  property p_unknown;
    req_wr && !(reg_wdata[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
      |=> $stable(current_state) && change_flag;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code taken");
  property p_mbx;
    s_req(4'h2) ##0 current_state == 4'h1 |=> current_state == ($past(mbx_cfg_ok) ? 4'h2 : 4'h1);
  endproperty
  a_mbx: assert property (p_mbx) else $error("bad mailbox step");
  property p_wdog;
    sm_watchdog_expired && !in_cfg_fault && !out_cfg_fault && current_state == 4'h8
      |=> current_state == 4'h4 && change_flag;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog not taken");
endmodule // alsm_monitor
bind alsm_state_machine alsm_monitor chk_u (.clk, .rstn, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rd, .reg_rdata, .reg_rvalid, .mbx_cfg_ok, .sm_watchdog_expired, .out_cfg_fault,
  .in_cfg_fault, .unspecified_fault, .current_state, .change_flag);

// ---- alsm_reset_sync.v ----
// Two-stage release synchroniser for the active-low reset
`timescale 1ns/1ps
module alsm_reset_sync (
  input wire clk,
  input wire rstn,
  output wire rst_sync_n
);
  reg stage1;
  reg stage2;

  // Assert at once, release only after two clean edges
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= 1'b1;
      stage2 <= stage1;
    end
  end

  assign rst_sync_n = stage2;
endmodule // alsm_reset_sync

// ---- alsm_state_machine.v ----
// Slave application-layer state machine with its three registers
//
// Function
// - Request write triggers transition attempt
// - Decode request codes 1,2,3,4,8
// - Acknowledge bit one clears change flag
// - Report current state in bits 0-3
// - Status bit 4 flags a refused request or a fault
// - Failed transition sets flag, loads code
// - Codes 0000, 0001, 0012 behaviour
// - Illegal transitions refused with 0011
// - Bad mailbox setup keeps Init, 0015/0016
// - Bad sync manager setup gives 0017
// - Watchdog/output faults drop Op to SafeOp, input faults drop Op/SafeOp to PreOp
`timescale 1ns/1ps
`include "alsm_defines.vh"
module alsm_state_machine #(
  parameter ADDR_W = 16,
  parameter DATA_W = 16
) (
  input wire clk,
  input wire rstn,
  input wire [ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire [DATA_W-1:0] reg_wdata,
  input wire reg_rd,
  output reg [DATA_W-1:0] reg_rdata,
  output reg reg_rvalid,
  input wire mbx_cfg_ok,
  input wire sm_cfg_ok,
  input wire out_cfg_ok,
  input wire in_cfg_ok,
  input wire sm_watchdog_expired,
  input wire out_cfg_fault,
  input wire in_cfg_fault,
  input wire unspecified_fault,
  output reg [3:0] current_state,
  output reg change_flag
);
  wire rst_n;
  reg [DATA_W-1:0] state_request;
  reg [DATA_W-1:0] transition_error_code;
  reg [3:0] next_state;
  reg next_flag;
  reg [DATA_W-1:0] next_code;
  reg known_req;
  wire req_wr;
  wire [3:0] req_state;
  wire [DATA_W-1:0] state_report;

  alsm_reset_sync u_reset_sync (
    .clk(clk),
    .rstn(rstn),
    .rst_sync_n(rst_n)
  );

  // ****************************************
  // Request register
  // ****************************************
  assign req_wr = reg_wr && (reg_addr == `ALSM_OFS_STATE_REQUEST);
  assign req_state = reg_wdata[`ALSM_STATE_MSB:0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_request <= `ALSM_RST_REQUEST;
    end else if (req_wr) begin
      state_request <= reg_wdata;
    end
  end

  // ****************************************
  // Transition evaluation
  // ****************************************
  always @* begin
    next_state = current_state;
    next_flag = change_flag;
    next_code = transition_error_code;
    known_req = 1'b0;
    if (req_wr) begin
      // Ack clears first so a fault raised by the same write still wins
      if (reg_wdata[`ALSM_ACK_BIT]) begin
        next_flag = 1'b0;
      end
      case (req_state)
        `ALSM_ST_INIT, `ALSM_ST_PREOP, `ALSM_ST_BOOT, `ALSM_ST_SAFEOP, `ALSM_ST_OP: begin
          known_req = 1'b1;
        end
        default: begin
          known_req = 1'b0;
        end
      endcase
      if (!known_req) begin
        next_flag = 1'b1;
        next_code = `ALSM_ERR_UNKNOWN;
      end else if (req_state == current_state) begin
        // Already there: state and code are left alone
        next_code = transition_error_code;
      end else if (req_state == `ALSM_ST_INIT) begin
        next_state = `ALSM_ST_INIT;
        next_code = `ALSM_ERR_NONE;
      end else begin
        case (current_state)
          `ALSM_ST_INIT: begin
            if (req_state == `ALSM_ST_PREOP || req_state == `ALSM_ST_BOOT) begin
              if (!mbx_cfg_ok) begin
                next_flag = 1'b1;
                next_code = (req_state == `ALSM_ST_BOOT) ?
                  `ALSM_ERR_MBX_BOOT : `ALSM_ERR_MBX_PREOP;
              end else begin
                next_state = req_state;
                next_code = `ALSM_ERR_NONE;
              end
            end else begin
              next_flag = 1'b1;
              next_code = `ALSM_ERR_BAD_CHANGE;
            end
          end
          `ALSM_ST_PREOP: begin
            if (req_state == `ALSM_ST_SAFEOP) begin
              if (!sm_cfg_ok) begin
                next_flag = 1'b1;
                next_code = `ALSM_ERR_SM_CFG;
              end else if (!out_cfg_ok) begin
                next_flag = 1'b1;
                next_code = `ALSM_ERR_OUT_CFG;
              end else if (!in_cfg_ok) begin
                next_flag = 1'b1;
                next_code = `ALSM_ERR_IN_CFG;
              end else begin
                next_state = `ALSM_ST_SAFEOP;
                next_code = `ALSM_ERR_NONE;
              end
            end else begin
              next_flag = 1'b1;
              next_code = `ALSM_ERR_BAD_CHANGE;
            end
          end
          `ALSM_ST_SAFEOP: begin
            if (req_state == `ALSM_ST_OP) begin
              if (!sm_cfg_ok) begin
                next_flag = 1'b1;
                next_code = `ALSM_ERR_SM_CFG;
              end else begin
                next_state = `ALSM_ST_OP;
                next_code = `ALSM_ERR_NONE;
              end
            end else if (req_state == `ALSM_ST_PREOP) begin
              next_state = `ALSM_ST_PREOP;
              next_code = `ALSM_ERR_NONE;
            end else begin
              next_flag = 1'b1;
              next_code = `ALSM_ERR_BAD_CHANGE;
            end
          end
          `ALSM_ST_OP: begin
            if (req_state == `ALSM_ST_SAFEOP || req_state == `ALSM_ST_PREOP) begin
              next_state = req_state;
              next_code = `ALSM_ERR_NONE;
            end else begin
              next_flag = 1'b1;
              next_code = `ALSM_ERR_BAD_CHANGE;
            end
          end
          default: begin
            // Bootstrap only leaves toward Init
            next_flag = 1'b1;
            next_code = `ALSM_ERR_BAD_CHANGE;
          end
        endcase
      end
    end
    // Local faults override the request in the same cycle
    if (current_state == `ALSM_ST_OP || current_state == `ALSM_ST_SAFEOP) begin
      if (in_cfg_fault) begin
        next_state = `ALSM_ST_PREOP;
        next_flag = 1'b1;
        next_code = `ALSM_ERR_IN_CFG;
      end else if (out_cfg_fault) begin
        next_state = `ALSM_ST_SAFEOP;
        next_flag = 1'b1;
        next_code = `ALSM_ERR_OUT_CFG;
      end else if (sm_watchdog_expired) begin
        next_state = `ALSM_ST_SAFEOP;
        next_flag = 1'b1;
        next_code = `ALSM_ERR_SM_WDOG;
      end else if (unspecified_fault) begin
        next_flag = 1'b1;
        next_code = `ALSM_ERR_UNSPEC;
      end
    end else if (unspecified_fault) begin
      next_flag = 1'b1;
      next_code = `ALSM_ERR_UNSPEC;
    end
  end

  // ****************************************
  // State, flag and code registers
  // ****************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      current_state <= `ALSM_RST_STATE;
      change_flag <= 1'b0;
      transition_error_code <= `ALSM_RST_CODE;
    end else begin
      current_state <= next_state;
      change_flag <= next_flag;
      transition_error_code <= next_code;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  assign state_report = {{(DATA_W-5){1'b0}}, change_flag, current_state};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= {DATA_W{1'b0}};
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `ALSM_OFS_STATE_REQUEST: begin
            reg_rdata <= state_request;
          end
          `ALSM_OFS_STATE_REPORT: begin
            reg_rdata <= state_report;
          end
          `ALSM_OFS_ERROR_CODE: begin
            reg_rdata <= transition_error_code;
          end
          default: begin
            // Unmapped offsets read as zero
            reg_rdata <= {DATA_W{1'b0}};
          end
        endcase
      end
    end
  end
endmodule // alsm_state_machine

// ---- testbench.sv ----
// Randomised self-checking bench for the slave state machine
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [3:0] ok = 4'hF;
  reg [3:0] flt = 4'h0;
  wire [15:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_rvalid, chg;
  wire [3:0] cur;
  integer err_count = 0;
  integer checked = 0;
  integer i;
  reg [15:0] q;
  reg [31:0] e;
  reg [2:0] k;
  reg [3:0] m_st = 4'h1;
  reg m_fl = 1'b0;
  reg [15:0] m_cd = 16'h0000;
  localparam [19:0] CODES = {4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
  always #12.5 clk = ~clk;
  alsm_state_machine dut_u (.clk, .rstn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .mbx_cfg_ok(ok[0]), .sm_cfg_ok(ok[1]), .out_cfg_ok(ok[2]), .in_cfg_ok(ok[3]),
    .sm_watchdog_expired(flt[0]), .out_cfg_fault(flt[1]), .in_cfg_fault(flt[2]),
    .unspecified_fault(flt[3]), .current_state(cur), .change_flag(chg));
  alsm_master master_u (.clk, .reg_rvalid, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  function [19:0] f_req(input [3:0] s, input [3:0] r);
    begin
      f_req = {16'h0011, s};
      if (!(r inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8}))
        f_req = {16'h0012, s};
      else if (r == 4'h1 || (s == 4'h8 && r != 4'h3) || (s == 4'h4 && r == 4'h2))
        f_req = {16'h0000, r};
      else if (s == 4'h1 && (r == 4'h2 || r == 4'h3))
        f_req = ok[0] ? {16'h0000, r} : {(r == 4'h3 ? 16'h0015 : 16'h0016), s};
      else if (s == 4'h2 && r == 4'h4)
        f_req = !ok[1] ? {16'h0017, s} : !ok[2] ? {16'h001D, s} :
          !ok[3] ? {16'h001E, s} : {16'h0000, r};
      else if (s == 4'h4 && r == 4'h8)
        f_req = ok[1] ? {16'h0000, r} : {16'h0017, s};
    end
  endfunction
  // Zero code means the fault has no effect in this state
  function [19:0] f_flt(input [3:0] s, input [2:0] k);
    begin
      f_flt = {16'h0000, s};
      if (k == 3'h3)
        f_flt = {16'h0001, s};
      else if (s == 4'h8 || s == 4'h4)
        f_flt = (k == 3'h2) ? {16'h001E, 4'h2} : {(k == 3'h1 ? 16'h001D : 16'h001B), 4'h4};
    end
  endfunction
  initial begin
    i = $urandom(35);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    master_u.rd(16'h0130, q);
    chk(q, 16'h0001);
    master_u.rd(16'h0134, q);
    chk(q, 16'h0000);
    master_u.rd(16'h0122, q);
    chk(q, 16'h0000);
    master_u.rd(16'h0120, q);
    chk(q, 16'h0001);
    master_u.wr(16'h0130, 16'hFFFF);
    master_u.rd(16'h0130, q);
    chk(q, 16'h0001);
    for (i = 0; i < 400; i = i + 1) begin
      e = $urandom | $urandom;
      ok <= e[3:0];
      k = $urandom % 6;
      e = $urandom;
      if (k < 3'h4) begin
        @(posedge clk);
        flt <= 4'h1 << k;
        @(posedge clk);
        flt <= 4'h0;
        e[19:0] = f_flt(m_st, k);
        m_fl = m_fl | (e[19:4] != 16'h0000);
        if (e[19:4] != 16'h0000)
          {m_cd, m_st} = e[19:0];
      end else begin
        if (k == 3'h4)
          e[3:0] = CODES[4 * (e[10:8] % 5) +: 4];
        master_u.wr(16'h0120, {11'h000, e[4:0]});
        master_u.rd(16'h0120, q);
        chk(q, {11'h000, e[4:0]});
        m_fl = m_fl & !e[4];
        if (e[3:0] != m_st) begin
          {m_cd, m_st} = f_req(m_st, e[3:0]);
          m_fl = m_fl | (m_cd != 16'h0000);
        end
      end
      master_u.rd(16'h0130, q);
      chk(q, {11'h000, m_fl, m_st});
      chk({12'h000, cur}, {12'h000, m_st});
      chk({15'h0000, chg}, {15'h0000, m_fl});
      master_u.rd(16'h0134, q);
      chk(q, m_cd);
    end
    // Mid-run reset must bring everything back to its start values
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    master_u.rd(16'h0130, q);
    chk(q, 16'h0001);
    chk({15'h0000, chg}, 16'h0000);
    master_u.rd(16'h0134, q);
    chk(q, 16'h0000);
    master_u.rd(16'h0120, q);
    chk(q, 16'h0001);
    finish_test;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count = err_count + 1;
    finish_test;
  end
endmodule // testbench
